// ===== pwm_cc_pkg.sv
// Constants, register map and state types of the six-channel modulator
`default_nettype none
package pwm_cc_pkg;

  localparam int CHANNELS   = 6;
  localparam int ADDR_W     = 7;
  localparam int PRESCALE_W = 7;

  // ****************************************
  // Register indices, byte address = 4 * index
  // ****************************************
  localparam logic [4:0] IDX_ENABLE    = 5'h00;
  localparam logic [4:0] IDX_POLARITY  = 5'h01;
  localparam logic [4:0] IDX_CLOCK_SEL = 5'h02;
  localparam logic [4:0] IDX_PRESCALE  = 5'h03;
  localparam logic [4:0] IDX_ALIGN     = 5'h04;
  localparam logic [4:0] IDX_CONTROL   = 5'h05;
  localparam logic [4:0] IDX_SCALE_A   = 5'h06;
  localparam logic [4:0] IDX_SCALE_B   = 5'h07;
  localparam logic [4:0] IDX_COUNTER   = 5'h08;
  localparam logic [4:0] IDX_PERIOD    = 5'h0e;
  localparam logic [4:0] IDX_DUTY      = 5'h14;
  localparam logic [4:0] IDX_LAST      = 5'h19;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int         PRE_A_LSB     = 0;
  localparam int         PRE_B_LSB     = 4;
  localparam int         PRE_W         = 3;
  localparam logic [7:0] PRESCALE_MASK = 8'h77;
  localparam int         JOIN_LSB      = 4;
  localparam logic [7:0] CONTROL_MASK  = 8'h70;
  localparam logic [7:0] CLK_SEL_MASK  = 8'h3f;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] PERIOD_RESET  = 8'hff;
  localparam logic [7:0] DUTY_RESET    = 8'hff;
  localparam logic [8:0] SCALE_FULL    = 9'h1ff;

  typedef enum logic {CNT_UP, CNT_DOWN} dir_t;

  typedef struct packed {
    logic [7:0]                         enable;
    logic [7:0]                         polarity;
    logic [7:0]                         clock_sel;
    logic [7:0]                         prescale;
    logic [7:0]                         align;
    logic [7:0]                         control;
    logic [7:0]                         scale_a;
    logic [7:0]                         scale_b;
    logic [CHANNELS-1:0][7:0]           period;
    logic [CHANNELS-1:0][7:0]           duty;
    logic [CHANNELS-1:0][7:0]           counter;
    dir_t [CHANNELS-1:0]                dir;
    logic [PRESCALE_W-1:0]              prescale_cnt;
    logic [8:0]                         sa_cnt;
    logic [8:0]                         sb_cnt;
    logic [CHANNELS-1:0]                pwm_out;
    logic [31:0]                        prdata;
  } state_t;

endpackage
`default_nettype wire

// ===== pwm_clock_select_center_concat.sv
// Six-channel modulator: clock selection, center mode and channel joining
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// Function
// RULE_01 - Channels 0,1,4,5 count on clock A, or on SA when selected.
// RULE_02 - Channels 2,3 count on clock B, or on SB when selected.
// RULE_03 - Prescale register holds separate three-bit dividers for A and B.
// RULE_04 - Prescale writable anytime; one pulse may be cut or stretched.
// RULE_05 - Center period is twice the period value in selected clock ticks.
// RULE_06 - Center, polarity 0: high fraction is (period - duty) / period.
// RULE_07 - Center mode, polarity 1: high fraction is duty over period.
// RULE_08 - Runs as six 8-bit channels or up to three joined 16-bit channels.
// RULE_09 - Control register holds three join bits for pairs 0/1, 2/3, 4/5.
// RULE_10 - In a joined pair the lower channel holds the high-order bytes.
// RULE_11 - Software changes a join bit only while both channels are off.
// RULE_12 - Joined pair uses upper channel's settings, enable and output pin.
module pwm_clock_select_center_concat
  import pwm_cc_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic      [CHANNELS-1:0] pwm_out
);

  state_t              s;
  state_t              next_s;
  logic [4:0]          idx;
  logic                mapped;
  logic                wr_en;
  logic                rd_setup;
  logic [PRESCALE_W-1:0] mask_a;
  logic [PRESCALE_W-1:0] mask_b;
  logic                tick_a;
  logic                tick_b;
  logic                tick_sa;
  logic                tick_sb;
  logic [8:0]          limit_a;
  logic [8:0]          limit_b;
  logic [CHANNELS-1:0] chan_tick;
  logic [CHANNELS-1:0] joined;
  logic [CHANNELS-1:0] active;
  logic [CHANNELS-1:0] level;
  logic [15:0]         cnt16  [CHANNELS];
  logic [15:0]         per16  [CHANNELS];
  logic [15:0]         duty16 [CHANNELS];

  // ****************************************
  // APB slave
  // ****************************************
  assign idx      = paddr[6:2];
  assign mapped   = (idx <= IDX_LAST);
  assign wr_en    = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  // Zero wait states; read data is captured in the setup cycle
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign prdata   = s.prdata;
  assign pwm_out  = s.pwm_out;

  // ****************************************
  // Base and scaled clock ticks
  // ****************************************
  // Base clocks divide the bus clock by two to the field value
  // RULE_03 two dividers
  assign mask_a  = PRESCALE_W'((8'h01 << s.prescale[PRE_A_LSB +: PRE_W])
                               - 8'h01);
  assign mask_b  = PRESCALE_W'((8'h01 << s.prescale[PRE_B_LSB +: PRE_W])
                               - 8'h01);
  assign tick_a  = (s.prescale_cnt & mask_a) == mask_a;
  assign tick_b  = (s.prescale_cnt & mask_b) == mask_b;
  // Scaled clock period is twice the scale value, zero meaning 256
  assign limit_a = (s.scale_a == 8'h00) ? SCALE_FULL
                                        : {s.scale_a, 1'b0} - 9'h001;
  assign limit_b = (s.scale_b == 8'h00) ? SCALE_FULL
                                        : {s.scale_b, 1'b0} - 9'h001;
  assign tick_sa = tick_a && (s.sa_cnt >= limit_a);
  assign tick_sb = tick_b && (s.sb_cnt >= limit_b);

  // ****************************************
  // Per-channel view, 8 or 16 bit
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : gen_ch
      localparam bit USES_B = (g == 2) || (g == 3);
      localparam bit ODD    = (g % 2) == 1;
      localparam int LOWER  = (g / 2) * 2;
      logic [7:0] hi_cnt;
      logic [7:0] hi_per;
      logic [7:0] hi_duty;

      assign joined[g] = s.control[JOIN_LSB + g / 2];
      // RULE_01 group A select
      // RULE_02 group B select
      assign chan_tick[g] = s.clock_sel[g] ? (USES_B ? tick_sb : tick_sa)
                                           : (USES_B ? tick_b : tick_a);
      // RULE_12 lower channel idle
      assign active[g] = s.enable[g] && !(joined[g] && !ODD);
      // RULE_10 lower holds high bytes
      assign hi_cnt  = (ODD && joined[g]) ? s.counter[LOWER] : 8'h00;
      assign hi_per  = (ODD && joined[g]) ? s.period[LOWER]  : 8'h00;
      assign hi_duty = (ODD && joined[g]) ? s.duty[LOWER]    : 8'h00;
      // RULE_08 8 or 16 bit view
      assign cnt16[g]  = {hi_cnt,  s.counter[g]};
      assign per16[g]  = {hi_per,  s.period[g]};
      assign duty16[g] = {hi_duty, s.duty[g]};
      // RULE_06 polarity 0 high at or above duty
      // RULE_07 polarity 1 high below duty
      assign level[g] = s.polarity[g] ? (cnt16[g] < duty16[g])
                                      : (cnt16[g] >= duty16[g]);
    end
  endgenerate

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [15:0] nxt;
    nxt    = 16'h0000;
    next_s = s;
    next_s.prescale_cnt = s.prescale_cnt + PRESCALE_W'(1);
    if (tick_a) begin
      next_s.sa_cnt = tick_sa ? 9'h000 : s.sa_cnt + 9'h001;
    end
    if (tick_b) begin
      next_s.sb_cnt = tick_sb ? 9'h000 : s.sb_cnt + 9'h001;
    end

    for (int i = 0; i < CHANNELS; i++) begin
      nxt = cnt16[i];
      if (!active[i]) begin
        nxt = 16'h0000;
        next_s.dir[i] = CNT_UP;
      end else if (chan_tick[i] && per16[i] != 16'h0000) begin
        if (!s.align[i]) begin
          nxt = (cnt16[i] >= per16[i] - 16'h0001) ? 16'h0000
                                                  : cnt16[i] + 16'h0001;
        end else begin
          // RULE_05 up then down, each value twice
          case (s.dir[i])
            CNT_UP: begin
              if (cnt16[i] >= per16[i] - 16'h0001) begin
                next_s.dir[i] = CNT_DOWN;
              end else begin
                nxt = cnt16[i] + 16'h0001;
              end
            end
            CNT_DOWN: begin
              if (cnt16[i] == 16'h0000) begin
                next_s.dir[i] = CNT_UP;
              end else begin
                nxt = cnt16[i] - 16'h0001;
              end
            end
            default: next_s.dir[i] = CNT_UP;
          endcase
        end
      end
      // RULE_10 carry into lower channel
      if (!(joined[i] && (i % 2 == 0))) begin
        next_s.counter[i] = nxt[7:0];
      end
      if (joined[i] && (i % 2 == 1)) begin
        next_s.counter[(i / 2) * 2] = nxt[15:8];
      end
      // RULE_12 pin of the upper channel
      next_s.pwm_out[i] = active[i] && level[i];
    end

    if (rd_setup) begin
      next_s.prdata = 32'h0000_0000;
      case (idx)
        IDX_ENABLE:    next_s.prdata[7:0] = s.enable;
        IDX_POLARITY:  next_s.prdata[7:0] = s.polarity;
        IDX_CLOCK_SEL: next_s.prdata[7:0] = s.clock_sel;
        IDX_PRESCALE:  next_s.prdata[7:0] = s.prescale;
        IDX_ALIGN:     next_s.prdata[7:0] = s.align;
        IDX_CONTROL:   next_s.prdata[7:0] = s.control;
        IDX_SCALE_A:   next_s.prdata[7:0] = s.scale_a;
        IDX_SCALE_B:   next_s.prdata[7:0] = s.scale_b;
        default: begin
          for (int i = 0; i < CHANNELS; i++) begin
            if (idx == IDX_COUNTER + 5'(i)) next_s.prdata[7:0] = s.counter[i];
            if (idx == IDX_PERIOD + 5'(i))  next_s.prdata[7:0] = s.period[i];
            if (idx == IDX_DUTY + 5'(i))    next_s.prdata[7:0] = s.duty[i];
          end
        end
      endcase
    end

    if (wr_en) begin
      case (idx)
        IDX_ENABLE:    next_s.enable    = pwdata[7:0] & CLK_SEL_MASK;
        IDX_POLARITY:  next_s.polarity  = pwdata[7:0] & CLK_SEL_MASK;
        IDX_CLOCK_SEL: next_s.clock_sel = pwdata[7:0] & CLK_SEL_MASK;
        // RULE_04 no gating on running channels
        IDX_PRESCALE:  next_s.prescale  = pwdata[7:0] & PRESCALE_MASK;
        IDX_ALIGN:     next_s.align     = pwdata[7:0] & CLK_SEL_MASK;
        // RULE_09 three join bits
        IDX_CONTROL:   next_s.control   = pwdata[7:0] & CONTROL_MASK;
        IDX_SCALE_A: begin
          next_s.scale_a = pwdata[7:0];
          next_s.sa_cnt  = 9'h000;
        end
        IDX_SCALE_B: begin
          next_s.scale_b = pwdata[7:0];
          next_s.sb_cnt  = 9'h000;
        end
        default: begin
          // Counter writes clear that counter byte; an unjoined channel restarts from zero
          for (int i = 0; i < CHANNELS; i++) begin
            if (idx == IDX_COUNTER + 5'(i)) begin
              next_s.counter[i] = 8'h00;
              next_s.dir[i]     = CNT_UP;
            end
            if (idx == IDX_PERIOD + 5'(i)) next_s.period[i] = pwdata[7:0];
            if (idx == IDX_DUTY + 5'(i))   next_s.duty[i]   = pwdata[7:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s              <= '0;
      s.enable       <= REG_RESET;
      s.polarity     <= REG_RESET;
      s.clock_sel    <= REG_RESET;
      s.prescale     <= REG_RESET;
      s.align        <= REG_RESET;
      s.control      <= REG_RESET;
      s.scale_a      <= REG_RESET;
      s.scale_b      <= REG_RESET;
      s.period       <= {CHANNELS{PERIOD_RESET}};
      s.duty         <= {CHANNELS{DUTY_RESET}};
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence seq_prescale_write;
    wr_en && idx == IDX_PRESCALE;
  endsequence

  AST_CH0_CLOCK_A: assert property ( // RULE_01
    chan_tick[0] == (s.clock_sel[0] ? tick_sa : tick_a))
    else $error("channel 0 clock select wrong");

  AST_CH3_CLOCK_B: assert property ( // RULE_02
    chan_tick[3] == (s.clock_sel[3] ? tick_sb : tick_b))
    else $error("channel 3 clock select wrong");

  AST_PRESCALE_FIELDS: assert property ( // RULE_03
    seq_prescale_write |=> s.prescale == ($past(pwdata[7:0]) & PRESCALE_MASK)
      ##1 (s.prescale[PRE_A_LSB +: PRE_W] != 3'h0 || tick_a))
    else $error("prescale field not applied");

  AST_PRESCALE_RUNNING: assert property ( // RULE_04
    (seq_prescale_write and s.enable != 8'h00) |=>
      s.prescale == ($past(pwdata[7:0]) & PRESCALE_MASK))
    else $error("prescale write lost while running");

  AST_BASE_B_DIVIDED: assert property ( // RULE_03
    (tick_b && s.prescale[PRE_B_LSB +: PRE_W] != 3'h0 && !wr_en) |=>
      !tick_b)
    else $error("divided base clock B ticked twice in a row");

  AST_JOIN_BITS: assert property ( // RULE_09
    (wr_en && idx == IDX_CONTROL) |=>
      joined[1] == $past(pwdata[JOIN_LSB]) &&
      joined[3] == $past(pwdata[JOIN_LSB + 1]) &&
      joined[5] == $past(pwdata[JOIN_LSB + 2]))
    else $error("join bits not applied");

  generate
    for (g = 0; g < CHANNELS; g++) begin : gen_ast
      sequence seq_top;
        active[g] && s.align[g] && chan_tick[g] && s.dir[g] == CNT_UP &&
        per16[g] != 16'h0000 && cnt16[g] == per16[g] - 16'h0001;
      endsequence

      sequence seq_bottom;
        active[g] && s.align[g] && chan_tick[g] && s.dir[g] == CNT_DOWN &&
        per16[g] != 16'h0000 && cnt16[g] == 16'h0000 && !wr_en;
      endsequence

      AST_CENTER_TURN: assert property ( // RULE_05
        seq_top |=> s.dir[g] == CNT_DOWN && cnt16[g] == $past(cnt16[g]))
        else $error("center count did not turn at period");

      AST_CENTER_BOTTOM: assert property ( // RULE_05
        seq_bottom |=> s.dir[g] == CNT_UP && cnt16[g] == 16'h0000)
        else $error("center count did not turn at zero");

      AST_COUNT_ON_TICK: assert property ( // RULE_01
        (active[g] && !chan_tick[g] && !wr_en) |=>
          cnt16[g] == $past(cnt16[g]))
        else $error("counter moved without its clock tick");

      AST_POL0_LEVEL: assert property ( // RULE_06
        (active[g] && !s.polarity[g]) |=>
          s.pwm_out[g] == ($past(cnt16[g]) >= $past(duty16[g])))
        else $error("polarity 0 output level wrong");

      AST_POL1_LEVEL: assert property ( // RULE_07
        (active[g] && s.polarity[g]) |=>
          s.pwm_out[g] == ($past(cnt16[g]) < $past(duty16[g])))
        else $error("polarity 1 output level wrong");

      if (g % 2 == 0) begin : gen_lower
        AST_JOINED_LOWER_IDLE: assert property ( // RULE_12
          joined[g] |=> !s.pwm_out[g])
          else $error("joined lower channel drove its pin");
      end else begin : gen_upper
        AST_JOIN_CARRY: assert property ( // RULE_10
          (active[g] && joined[g] && chan_tick[g] && !wr_en &&
           (!s.align[g] || s.dir[g] == CNT_UP) && per16[g] != 16'h0000 &&
           s.counter[g] == 8'hff && cnt16[g] < per16[g] - 16'h0001) |=>
            s.counter[g - 1] == $past(s.counter[g - 1]) + 8'h01)
          else $error("joined counter carry missing");

        AST_JOIN_UPPER_ENABLE: assert property ( // RULE_12
          (joined[g] && !s.enable[g]) |=>
            cnt16[g] == 16'h0000 && !s.pwm_out[g])
          else $error("joined channel ran while upper disabled");
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ===== pwm_load.sv
// Load model on the modulator pins: counts high samples and rising edges
`timescale 1ns/1ns
`default_nettype none
module pwm_load (
  input  wire logic             pclk,
  input  wire logic             meas,
  input  wire logic [5:0]       pins,
  output logic      [5:0][15:0] high_cnt,
  output logic      [5:0][15:0] rise_cnt
);
  logic [5:0] last;

  // Counts clear whenever the window is closed
  always_ff @(posedge pclk) begin
    last <= pins;
    for (int i = 0; i < 6; i++) begin
      if (!meas) begin
        high_cnt[i] <= 16'h0000;
        rise_cnt[i] <= 16'h0000;
      end else begin
        high_cnt[i] <= high_cnt[i] + 16'(pins[i]);
        rise_cnt[i] <= rise_cnt[i] + 16'(pins[i] & ~last[i]);
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the six-channel modulator
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pwm_cc_pkg::*;
  logic                 pclk, presetn, psel, penable, pwrite, meas;
  logic [ADDR_W-1:0]    paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic                 pready, pslverr, err;
  logic [CHANNELS-1:0]  pwm_out;
  logic [5:0][15:0]     high_cnt, rise_cnt;
  int                   fail_count = 0;
  int                   tests_run = 0;

  pwm_clock_select_center_concat u_pwm_clock_select_center_concat (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out));
  pwm_load u_pwm_load (.pclk(pclk), .meas(meas), .pins(pwm_out),
    .high_cnt(high_cnt), .rise_cnt(rise_cnt));

  always #4 pclk = ~pclk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic apb(input logic wr, input logic [4:0] idx,
                     input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) begin
      fail_count++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Window of n samples after letting the waveform settle
  task automatic measure(input int n, input int settle);
    repeat (settle) @(posedge pclk);
    meas <= 1'b1;
    repeat (n) @(posedge pclk);
    meas <= 1'b0;
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic sc_regs;
    apb(1'b0, IDX_PRESCALE, 8'h00);
    check(rd, 32'h00000000);
    apb(1'b0, IDX_PERIOD, 8'h00);
    check(rd, 32'h000000ff);
    apb(1'b0, 5'h1a, 8'h00);
    check({31'h0, err}, 32'h00000001);
    apb(1'b1, IDX_PRESCALE, 8'hff);
    apb(1'b0, IDX_PRESCALE, 8'h00);
    check(rd, 32'h00000077);
    apb(1'b1, IDX_PRESCALE, 8'h35);
    apb(1'b0, IDX_PRESCALE, 8'h00);
    check(rd, 32'h00000035);
  endtask

  task automatic sc_center_a;
    do_reset;
    apb(1'b1, IDX_PERIOD, 8'h04);
    apb(1'b1, IDX_DUTY, 8'h01);
    apb(1'b1, IDX_ALIGN, 8'h01);
    apb(1'b1, IDX_ENABLE, 8'h01);
    measure(80, 16);
    check({16'h0, high_cnt[0]}, 32'd60);
    check({16'h0, rise_cnt[0]}, 32'd10);
    apb(1'b1, IDX_POLARITY, 8'h01);
    measure(80, 16);
    check({16'h0, high_cnt[0]}, 32'd20);
    // Divider changed while the channel runs
    apb(1'b1, IDX_PRESCALE, 8'h02);
    measure(320, 64);
    check({16'h0, high_cnt[0]}, 32'd80);
    check({16'h0, rise_cnt[0]}, 32'd10);
    apb(1'b1, IDX_SCALE_A, 8'h01);
    apb(1'b1, IDX_CLOCK_SEL, 8'h01);
    measure(640, 128);
    check({16'h0, high_cnt[0]}, 32'd160);
    check({16'h0, rise_cnt[0]}, 32'd10);
  endtask

  task automatic sc_center_b;
    do_reset;
    apb(1'b1, IDX_PRESCALE, 8'h17);
    apb(1'b1, IDX_PERIOD + 5'd2, 8'h04);
    apb(1'b1, IDX_DUTY + 5'd2, 8'h01);
    apb(1'b1, IDX_POLARITY, 8'h04);
    apb(1'b1, IDX_ALIGN, 8'h04);
    apb(1'b1, IDX_ENABLE, 8'h04);
    measure(160, 32);
    check({16'h0, high_cnt[2]}, 32'd40);
    check({16'h0, rise_cnt[2]}, 32'd10);
    apb(1'b1, IDX_SCALE_B, 8'h02);
    apb(1'b1, IDX_CLOCK_SEL, 8'h04);
    measure(640, 128);
    check({16'h0, high_cnt[2]}, 32'd160);
    check({16'h0, high_cnt[0]}, 32'd0);
  endtask

  task automatic sc_join;
    do_reset;
    // Period 0x0180 and duty 0x0100 make the count cross a byte
    apb(1'b1, IDX_PERIOD, 8'h01);
    apb(1'b1, IDX_PERIOD + 5'd1, 8'h80);
    apb(1'b1, IDX_DUTY, 8'h01);
    apb(1'b1, IDX_DUTY + 5'd1, 8'h00);
    apb(1'b1, IDX_POLARITY, 8'h02);
    apb(1'b1, IDX_ALIGN, 8'h02);
    // Join bits set while all channels are off
    apb(1'b1, IDX_CONTROL, 8'hff);
    apb(1'b0, IDX_CONTROL, 8'h00);
    check(rd, 32'h00000070);
    apb(1'b1, IDX_CONTROL, 8'h10);
    apb(1'b0, IDX_CONTROL, 8'h00);
    check(rd, 32'h00000010);
    apb(1'b1, IDX_ENABLE, 8'h02);
    // Two whole periods of 768 ticks, high while below 0x0100
    measure(1536, 600);
    check({16'h0, high_cnt[1]}, 32'd1024);
    check({16'h0, rise_cnt[1]}, 32'd2);
    check({16'h0, high_cnt[0]}, 32'd0);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h00000000;
    meas = 1'b0;
    do_reset;
    sc_regs;
    sc_center_a;
    sc_center_b;
    sc_join;
    test_done();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
